// ### hdl/bridge_order_pkg.sv
package bridge_order_pkg;

	localparam int AW = 32;
	localparam int DW = 32;
	localparam int BW = 4;
	localparam int PW_DEPTH = 4;
	localparam int PW_PTR = 2;
	localparam int CNT_W = 3;
	localparam int DIR_DOWN = 0;
	localparam int DIR_UP = 1;

	// Kind of transaction on a target bus, Gray along idle-write-request
	typedef enum logic [1:0] {
		K_NONE = 2'h0,
		K_PW = 2'h1,
		K_DREQ = 2'h3
	} issue_kind_e;

	typedef struct packed {
		logic [AW-1:0] addr;
		logic [DW-1:0] data;
		logic [BW-1:0] be;
	} wr_s;

	typedef struct packed {
		logic valid;
		logic is_read;
		wr_s w;
	} dreq_s;

	typedef struct packed {
		logic valid;
		logic is_read;
		logic [AW-1:0] addr;
		logic [DW-1:0] data;
		logic [CNT_W-1:0] ahead;
	} cpl_s;

	typedef struct packed {
		issue_kind_e kind;
		logic is_read;
		wr_s w;
	} issue_s;

	typedef struct packed {
		logic done;
		logic [DW-1:0] rdata;
	} rsp_s;

	typedef struct packed {
		wr_s [PW_DEPTH-1:0] mem;
		logic [PW_PTR-1:0] rd;
		logic [PW_PTR-1:0] wr;
		logic [CNT_W-1:0] cnt;
		logic full;
		dreq_s req;
		logic [CNT_W-1:0] req_ahead;
		cpl_s cpl;
		issue_s iss;
		logic prio_pw;
		logic rsp_v;
		rsp_s rsp;
	} dir_s;

	typedef struct packed {
		dir_s [1:0] dir;
	} state_s;

endpackage

// ### hdl/bridge_order.sv
`timescale 1ns/1ps
// Direction 0 runs primary to secondary, direction 1 the reverse.
// Each direction owns a posted write queue, one delayed request slot
// and one completion slot for answers to requests from its source side.
module bridge_order (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Posted writes arriving on the source bus of each direction
	input wire logic [1:0] pw_in_valid,
	input wire bridge_order_pkg::wr_s [1:0] pw_in,
	output logic [1:0] pw_in_ready,
	// Delayed request attempts on the source bus of each direction
	input wire logic [1:0] dreq_in_valid,
	input wire logic [1:0] dreq_in_read,
	input wire bridge_order_pkg::wr_s [1:0] dreq_in,
	output logic [1:0] dreq_rsp_valid,
	output bridge_order_pkg::rsp_s [1:0] dreq_rsp,
	// Transactions issued on the target bus of each direction
	output bridge_order_pkg::issue_s [1:0] iss,
	input wire logic [1:0] iss_done,
	input wire logic [1:0] iss_retry,
	input wire logic [1:0][bridge_order_pkg::DW-1:0] iss_rdata
);

	bridge_order_pkg::state_s s_r;
	bridge_order_pkg::state_s s_nxt;

	function automatic logic [bridge_order_pkg::PW_PTR-1:0] ptr_inc(
		input logic [bridge_order_pkg::PW_PTR-1:0] p);
		ptr_inc = p + bridge_order_pkg::PW_PTR'(1);
	endfunction

	function automatic logic [bridge_order_pkg::CNT_W-1:0] cnt_dec(
		input logic [bridge_order_pkg::CNT_W-1:0] c, input logic en);
		cnt_dec = (en && c != '0) ? c - bridge_order_pkg::CNT_W'(1) : c;
	endfunction

	// Next state for both directions
	always_comb begin
		logic [1:0] pop;
		logic push;
		logic match;
		logic can_pw;
		logic can_rq;
		int o;
		pop = '0;
		push = 1'b0;
		match = 1'b0;
		can_pw = 1'b0;
		can_rq = 1'b0;
		o = 0;
		s_nxt = s_r;
		for (int d = 0; d < 2; d++) begin
			pop[d] = s_r.dir[d].iss.kind == bridge_order_pkg::K_PW && iss_done[d];
		end
		for (int d = 0; d < 2; d++) begin
			o = 1 - d;
			s_nxt.dir[d].rsp_v = 1'b0;
			push = pw_in_valid[d] && !s_r.dir[d].full;
			if (push) begin
				s_nxt.dir[d].mem[s_r.dir[d].wr] = pw_in[d];
				s_nxt.dir[d].wr = ptr_inc(s_r.dir[d].wr);
			end
			if (pop[d]) begin
				s_nxt.dir[d].rd = ptr_inc(s_r.dir[d].rd);
			end
			s_nxt.dir[d].cnt = s_r.dir[d].cnt + bridge_order_pkg::CNT_W'(push)
				- bridge_order_pkg::CNT_W'(pop[d]);
			s_nxt.dir[d].full = s_nxt.dir[d].cnt == bridge_order_pkg::CNT_W'(bridge_order_pkg::PW_DEPTH);
			s_nxt.dir[d].req_ahead = cnt_dec(s_r.dir[d].req_ahead, pop[d]);
			s_nxt.dir[d].cpl.ahead = cnt_dec(s_r.dir[d].cpl.ahead, pop[o]);
			// Target side issue and its termination
			if (s_r.dir[d].iss.kind != bridge_order_pkg::K_NONE) begin
				if (iss_done[d]) begin
					s_nxt.dir[d].iss.kind = bridge_order_pkg::K_NONE;
					if (s_r.dir[d].iss.kind == bridge_order_pkg::K_DREQ) begin
						s_nxt.dir[d].cpl.valid = 1'b1;
						s_nxt.dir[d].cpl.is_read = s_r.dir[d].req.is_read;
						s_nxt.dir[d].cpl.addr = s_r.dir[d].req.w.addr;
						s_nxt.dir[d].cpl.data = s_r.dir[d].req.is_read ? iss_rdata[d] : '0;
						s_nxt.dir[d].cpl.ahead = s_r.dir[d].req.is_read ?
							s_r.dir[o].cnt - bridge_order_pkg::CNT_W'(pop[o]) : '0;
						s_nxt.dir[d].req.valid = 1'b0;
					end
				end else if (iss_retry[d]) begin
					s_nxt.dir[d].iss.kind = bridge_order_pkg::K_NONE;
				end
			end else begin
				can_pw = s_r.dir[d].cnt != '0;
				can_rq = s_r.dir[d].req.valid && s_r.dir[d].req_ahead == '0
					&& !s_r.dir[d].cpl.valid;
				if (can_pw && (!can_rq || s_r.dir[d].prio_pw)) begin
					s_nxt.dir[d].iss.kind = bridge_order_pkg::K_PW;
					s_nxt.dir[d].iss.is_read = 1'b0;
					s_nxt.dir[d].iss.w = s_r.dir[d].mem[s_r.dir[d].rd];
					s_nxt.dir[d].prio_pw = 1'b0;
				end else if (can_rq) begin
					s_nxt.dir[d].iss.kind = bridge_order_pkg::K_DREQ;
					s_nxt.dir[d].iss.is_read = s_r.dir[d].req.is_read;
					s_nxt.dir[d].iss.w = s_r.dir[d].req.w;
					s_nxt.dir[d].prio_pw = 1'b1;
				end
			end
			// Initiator side attempt: deliver, latch or retry
			if (dreq_in_valid[d]) begin
				s_nxt.dir[d].rsp_v = 1'b1;
				match = s_r.dir[d].cpl.valid && s_r.dir[d].cpl.addr == dreq_in[d].addr
					&& s_r.dir[d].cpl.is_read == dreq_in_read[d];
				if (match && s_r.dir[d].cpl.ahead == '0) begin
					s_nxt.dir[d].rsp.done = 1'b1;
					s_nxt.dir[d].rsp.rdata = s_r.dir[d].cpl.data;
					s_nxt.dir[d].cpl.valid = 1'b0;
				end else begin
					s_nxt.dir[d].rsp.done = 1'b0;
					s_nxt.dir[d].rsp.rdata = '0;
					if (!s_r.dir[d].req.valid && !s_r.dir[d].cpl.valid) begin
						s_nxt.dir[d].req.valid = 1'b1;
						s_nxt.dir[d].req.is_read = dreq_in_read[d];
						s_nxt.dir[d].req.w = dreq_in[d];
						s_nxt.dir[d].req_ahead = s_r.dir[d].cnt
							- bridge_order_pkg::CNT_W'(pop[d]);
					end
				end
			end
		end
	end

	// State register
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from state; no flush port exists
	// no interrupt flush
	always_comb begin
		for (int d = 0; d < 2; d++) begin
			pw_in_ready[d] = !s_r.dir[d].full;
			dreq_rsp_valid[d] = s_r.dir[d].rsp_v;
			dreq_rsp[d] = s_r.dir[d].rsp;
			iss[d] = s_r.dir[d].iss;
		end
	end

	// Checks per direction
	for (genvar g = 0; g < 2; g++) begin : g_chk
		a_pw_pop_order: assert property (@(posedge mclk) disable iff (!rst_b)
			(s_r.dir[g].iss.kind == bridge_order_pkg::K_PW && iss_done[g])
			|=> s_r.dir[g].rd == ptr_inc($past(s_r.dir[g].rd)))
			else $error("posted write queue did not advance in order");
		a_write_kept: assert property (@(posedge mclk) disable iff (!rst_b)
			(pw_in_valid[g] && pw_in_ready[g] && !(s_r.dir[g].iss.kind ==
			bridge_order_pkg::K_PW && iss_done[g]))
			|=> s_r.dir[g].cnt == bridge_order_pkg::CNT_W'($past(s_r.dir[g].cnt) + 1))
			else $error("accepted posted write was not queued");
		a_pw_accept_free: assert property (@(posedge mclk) disable iff (!rst_b)
			(s_r.dir[g].cnt != bridge_order_pkg::CNT_W'(bridge_order_pkg::PW_DEPTH))
			|-> pw_in_ready[g])
			else $error("posted write refused with room left");
		a_read_waits_writes: assert property (@(posedge mclk) disable iff (!rst_b)
			(s_r.dir[g].iss.kind != bridge_order_pkg::K_DREQ ##1
			s_r.dir[g].iss.kind == bridge_order_pkg::K_DREQ && iss[g].is_read)
			|-> $past(s_r.dir[g].req_ahead) == '0)
			else $error("delayed read issued ahead of posted writes");
		a_dwr_waits_writes: assert property (@(posedge mclk) disable iff (!rst_b)
			(iss[g].kind == bridge_order_pkg::K_DREQ && !iss[g].is_read)
			|-> s_r.dir[g].req_ahead == '0)
			else $error("delayed write passed posted writes");
		a_cpl_after_writes: assert property (@(posedge mclk) disable iff (!rst_b)
			(dreq_rsp_valid[g] && dreq_rsp[g].done)
			|-> $past(s_r.dir[g].cpl.valid) && $past(s_r.dir[g].cpl.ahead) == '0)
			else $error("completion returned before earlier writes");
		a_retry_first: assert property (@(posedge mclk) disable iff (!rst_b)
			(dreq_in_valid[g] && !s_r.dir[g].cpl.valid)
			|=> dreq_rsp_valid[g] && !dreq_rsp[g].done)
			else $error("new delayed request not retried");
		a_wcpl_passes: assert property (@(posedge mclk) disable iff (!rst_b)
			($rose(s_r.dir[g].cpl.valid) && !s_r.dir[g].cpl.is_read)
			|-> s_r.dir[g].cpl.ahead == '0)
			else $error("write completion held behind posted writes");
		a_arb_fair: assert property (@(posedge mclk) disable iff (!rst_b)
			(iss[g].kind == bridge_order_pkg::K_NONE && s_r.dir[g].cnt != '0
			&& s_r.dir[g].prio_pw) |=> iss[g].kind == bridge_order_pkg::K_PW)
			else $error("arbiter did not hand turn to posted queue");
		a_dreq_turn: assert property (@(posedge mclk) disable iff (!rst_b)
			(iss[g].kind == bridge_order_pkg::K_NONE && s_r.dir[g].req.valid
			&& s_r.dir[g].req_ahead == '0 && !s_r.dir[g].cpl.valid && !s_r.dir[g].prio_pw)
			|=> iss[g].kind == bridge_order_pkg::K_DREQ)
			else $error("arbiter did not hand turn to delayed slot");
		c_pw_done: cover property (@(posedge mclk) disable iff (!rst_b)
			iss[g].kind == bridge_order_pkg::K_PW && iss_done[g]);
		c_dreq_done: cover property (@(posedge mclk) disable iff (!rst_b)
			iss[g].kind == bridge_order_pkg::K_DREQ && iss_done[g]);
		c_cpl_given: cover property (@(posedge mclk) disable iff (!rst_b)
			dreq_rsp_valid[g] && dreq_rsp[g].done);
	end

	c_both_ways: cover property (@(posedge mclk) disable iff (!rst_b)
		iss[0].kind == bridge_order_pkg::K_PW && iss[1].kind == bridge_order_pkg::K_PW);

endmodule

// ### bench/order_target.sv
`timescale 1ns/1ps
module order_target (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Target bus of both directions
	input wire bridge_order_pkg::issue_s [1:0] iss,
	input wire logic slow,
	input wire logic refuse,
	output logic [1:0] iss_done,
	output logic [1:0] iss_retry,
	output logic [1:0][bridge_order_pkg::DW-1:0] iss_rdata
);
	int wait_c [2];
	// Answer each issue promptly or after a wait; idle read data keeps toggling
	always @(negedge mclk or negedge rst_b) begin
		for (int d = 0; d < 2; d++) begin
			iss_done[d] <= 1'b0;
			iss_retry[d] <= 1'b0;
			iss_rdata[d] <= ~iss_rdata[d];
			if (!rst_b) begin
				iss_rdata[d] <= '0;
				wait_c[d] <= 0;
			end else if (iss[d].kind == bridge_order_pkg::K_NONE) begin
				wait_c[d] <= slow ? 3 : 0;
			end else if (wait_c[d] > 0) begin
				wait_c[d] <= wait_c[d] - 1;
			end else if (!iss_done[d] && !iss_retry[d]) begin
				iss_done[d] <= !refuse;
				iss_retry[d] <= refuse;
				iss_rdata[d] <= ~iss[d].w.addr;
			end
		end
	end
endmodule

// ### bench/bridge_transaction_ordering_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] %0t got %h expected %h", $time, g, e); end end
module bridge_transaction_ordering_test;
	typedef struct packed {logic d; bridge_order_pkg::wr_s w;} row_s;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic slow = 1'b0;
	logic refuse = 1'b0;
	logic [1:0] pw_in_valid = '0;
	logic [1:0] dreq_in_valid = '0;
	logic [1:0] dreq_in_read = '0;
	logic [1:0] pw_in_ready, dreq_rsp_valid, iss_done, iss_retry;
	bridge_order_pkg::wr_s [1:0] pw_in = '0;
	bridge_order_pkg::wr_s [1:0] dreq_in = '0;
	bridge_order_pkg::rsp_s [1:0] dreq_rsp;
	bridge_order_pkg::rsp_s r;
	bridge_order_pkg::issue_s [1:0] iss;
	logic [1:0][bridge_order_pkg::DW-1:0] iss_rdata;
	bridge_order_pkg::issue_s log_q [2][$];
	bridge_order_pkg::issue_s exp_q [2][$];
	int n_fail = 0;
	int n_checks = 0;
	// Same address twice, split byte masks, both directions
	row_s rows [6] = '{'{1'b0, '{32'h0000_1000, 32'hA5A5_0001, 4'h1}},
		'{1'b0, '{32'h0000_1000, 32'hA5A5_0002, 4'h2}}, '{1'b1, '{32'h0000_2000, 32'h5A5A_0003, 4'hF}},
		'{1'b0, '{32'h0000_1000, 32'hA5A5_0004, 4'hC}}, '{1'b1, '{32'h0000_2000, 32'h5A5A_0005, 4'hF}},
		'{1'b0, '{32'h0000_1004, 32'hA5A5_0006, 4'hF}}};
	bridge_order_pkg::wr_s rd_w = '{32'h0000_3000, 32'h0000_0000, 4'hF};
	bridge_order_pkg::wr_s io_w = '{32'h0000_4000, 32'h1234_5678, 4'h3};

	always #10 mclk = ~mclk;

	bridge_order uut (.mclk(mclk), .rst_b(rst_b), .pw_in_valid(pw_in_valid), .pw_in(pw_in),
		.pw_in_ready(pw_in_ready), .dreq_in_valid(dreq_in_valid), .dreq_in_read(dreq_in_read),
		.dreq_in(dreq_in), .dreq_rsp_valid(dreq_rsp_valid), .dreq_rsp(dreq_rsp), .iss(iss),
		.iss_done(iss_done), .iss_retry(iss_retry), .iss_rdata(iss_rdata));

	order_target far (.mclk(mclk), .rst_b(rst_b), .iss(iss), .slow(slow), .refuse(refuse),
		.iss_done(iss_done), .iss_retry(iss_retry), .iss_rdata(iss_rdata));

	// Record every transaction that ends on a target bus without retry
	always @(posedge mclk) begin
		for (int d = 0; d < 2; d++) begin
			if (iss_done[d] === 1'b1 && iss[d].kind !== bridge_order_pkg::K_NONE) begin
				log_q[d].push_back(iss[d]);
			end
		end
	end

	task automatic post(input int d, input bridge_order_pkg::wr_s w);
		@(negedge mclk);
		pw_in_valid[d] = 1'b1;
		pw_in[d] = w;
		while (pw_in_ready[d] !== 1'b1) @(negedge mclk);
		@(negedge mclk);
		pw_in_valid[d] = 1'b0;
		exp_q[d].push_back('{bridge_order_pkg::K_PW, 1'b0, w});
	endtask

	task automatic attempt(input int d, input logic rd, input bridge_order_pkg::wr_s w);
		@(negedge mclk);
		dreq_in_valid[d] = 1'b1;
		dreq_in_read[d] = rd;
		dreq_in[d] = w;
		@(negedge mclk);
		dreq_in_valid[d] = 1'b0;
		`CHK(dreq_rsp_valid[d], 1'b1)
		r = dreq_rsp[d];
	endtask

	task automatic until_done(input int d, input logic rd, input bridge_order_pkg::wr_s w);
		attempt(d, rd, w);
		`CHK(r.done, 1'b0)
		for (int t = 0; t < 60 && r.done !== 1'b1; t++) begin
			repeat (3) @(negedge mclk);
			attempt(d, rd, w);
		end
		exp_q[d].push_back('{bridge_order_pkg::K_DREQ, rd, w});
	endtask

	task automatic final_report();
		if (n_fail == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge mclk);
		`CHK(pw_in_ready, 2'b11)
		`CHK(iss[0].kind, bridge_order_pkg::K_NONE)
		@(negedge mclk);
		rst_b = 1'b1;
		slow = 1'b1;
		foreach (rows[i]) post(int'(rows[i].d), rows[i].w);
		slow = 1'b0;
		post(0, rows[5].w);
		until_done(0, 1'b1, rd_w);
		`CHK(r.rdata, ~rd_w.addr)
		post(1, rows[2].w);
		until_done(1, 1'b0, io_w);
		`CHK(r.done, 1'b1)
		refuse = 1'b1;
		post(0, rows[3].w);
		repeat (12) @(negedge mclk);
		refuse = 1'b0;
		for (int t = 0; t < 300 && (log_q[0].size() < exp_q[0].size()
				|| log_q[1].size() < exp_q[1].size()); t++) @(negedge mclk);
		repeat (10) @(negedge mclk);
		for (int d = 0; d < 2; d++) begin
			`CHK(log_q[d].size(), exp_q[d].size())
			for (int i = 0; i < exp_q[d].size(); i++) begin
				`CHK(log_q[d][i], exp_q[d][i])
			end
		end
		// Reset in mid-run drops a write held by retries
		refuse = 1'b1;
		post(0, rows[0].w);
		repeat (3) @(negedge mclk);
		rst_b = 1'b0;
		@(negedge mclk);
		`CHK(iss[0].kind, bridge_order_pkg::K_NONE)
		`CHK(pw_in_ready, 2'b11)
		`CHK(dreq_rsp_valid, 2'b00)
		rst_b = 1'b1;
		refuse = 1'b0;
		post(1, rows[4].w);
		repeat (20) @(negedge mclk);
		`CHK(log_q[0].size() + 1, exp_q[0].size())
		`CHK(log_q[1].size(), exp_q[1].size())
		`CHK(log_q[1][$], exp_q[1][$])
		final_report();
	end

	// Watchdog well past the expected run length
	initial begin
		#200000;
		n_fail++;
		final_report();
	end
endmodule
